// ### design/mpt_timer.sv
// Match based modulation timer top
// Overview of operation
// R1 - Period match restarts counter, new cycle
// R2 - Single edge rises at cycle start
// R3 - Constant low output never rises
// R4 - Double edge: two matches set rise, fall
// R5 - Seven match registers, six outputs
// R6 - Per match continue, stop, reset, interrupt
// R7 - Clock or selected capture input counts
// R8 - 32-bit counter through 32-bit prescaler
// R9 - New values only after software release
// R10 - Without modulation, plain timer behaviour
// R11 - Master and slave units in lock step
// R12 - Any tick count; one shared rate
// R13 - Double edges anywhere in the cycle
// R14 - Match drives pins and interrupts
// R15 - Released values load at period match
// R16 - Flags sticky, cleared by writing one
`timescale 1ns/10ps
module mpt_timer
#(
   parameter int WIDTH = mpt_pkg::MPT_CNT_W
)
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic count_enable,
   input wire logic counter_reset,
   input wire logic pwm_mode,
   input wire logic slave_mode,
   input wire logic sync_run_in,
   input wire mpt_pkg::mpt_src_t count_src,
   input wire logic [1:0] cap_sel,
   input wire logic [mpt_pkg::MPT_NUM_CAP-1:0] cap_in,
   input wire logic [WIDTH-1:0] prescale,
   input wire logic [20:0] match_ctrl,
   input wire logic [5:0] double_sel,
   input wire logic [5:0] out_enable,
   input wire logic wr_en,
   input wire logic [mpt_pkg::MPT_IDX_W-1:0] wr_index,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic [6:0] release_set,
   input wire logic [6:0] flag_clear,
   output logic [5:0] pwm_out,
   output logic [6:0] match_flag,
   output logic irq,
   output logic run_out,
   output logic stopped,
   output logic [WIDTH-1:0] count_value,
   output logic [WIDTH-1:0] prescale_count
);
   import mpt_pkg::*;

   logic [6:0][WIDTH-1:0] active;
   logic [6:0] pending;
   logic cap_prev;
   logic [6:0] hit;
   logic [6:0] act_reset;
   logic [6:0] act_stop;
   logic [6:0] act_irq;
   logic [6:0] next_flag;
   logic [5:0] next_out;
   logic running;

   wire cap_now = cap_in[cap_sel];
   wire edge_rise = cap_now && !cap_prev;
   wire edge_fall = !cap_now && cap_prev;
   // R11 slave follows master run
   wire run_gate = slave_mode ? sync_run_in : run_out;
   wire active_cnt = run_gate && !stopped && !counter_reset;
   // R7 count source select
   wire src_event = (count_src == MPT_SRC_CLOCK) ||
                    (count_src == MPT_SRC_RISE && edge_rise) ||
                    (count_src == MPT_SRC_FALL && edge_fall) ||
                    (count_src == MPT_SRC_BOTH && (edge_rise || edge_fall));
   wire pre_wrap = prescale_count == prescale;
   wire tick = active_cnt && src_event && pre_wrap;
   // R12 one period match for all outputs
   wire period_hit = hit[0];
   wire any_reset = |(hit & act_reset);
   wire any_stop = |(hit & act_stop);

   // R5 seven match registers
   mpt_match_bank #(.WIDTH(WIDTH), .DEPTH(MPT_NUM_MATCH)) u_bank
   (
      .clock(clock),
      .sys_rst(sys_rst),
      .wr_en(wr_en),
      .wr_index(wr_index),
      .wr_data(wr_data),
      .release_set(release_set),
      .direct(!pwm_mode),
      .apply(period_hit),
      .active(active),
      .pending(pending)
   );

   always_comb
   begin
      for (int i = 0; i < MPT_NUM_MATCH; i++)
      begin
         // R14 match detection
         hit[i] = tick && (count_value == active[i]);
         act_irq[i] = match_ctrl[MPT_ACT_W*i + MPT_ACT_IRQ];
         act_stop[i] = match_ctrl[MPT_ACT_W*i + MPT_ACT_STOP];
         act_reset[i] = match_ctrl[MPT_ACT_W*i + MPT_ACT_RESET];
      end
      // R1 period match always restarts in modulation mode
      act_reset[0] = act_reset[0] || pwm_mode;
      // R16 set wins over clear
      next_flag = (match_flag & ~flag_clear) | (hit & act_irq);
   end

   always_comb
   begin
      for (int n = 1; n <= MPT_NUM_OUT; n++)
      begin
         next_out[n-1] = pwm_out[n-1];
         if (!out_enable[n-1] || !pwm_mode)
            next_out[n-1] = 1'b0;
         // R13 edges at any count position
         // R4 double edge: previous match rises, own match falls
         else if (double_sel[n-1] && n > 1)
         begin
            if (hit[n])
               next_out[n-1] = 1'b0;
            else if (hit[n-1])
               next_out[n-1] = 1'b1;
         end
         // R2 single edge fall at own match
         else if (hit[n])
            next_out[n-1] = 1'b0;
         // R3 zero match holds output low
         else if (period_hit)
            next_out[n-1] = (active[n] != MPT_MATCH_RST);
      end
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
         cap_prev <= 1'b0;
      else
         cap_prev <= cap_now;
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
         run_out <= 1'b0;
      else
         run_out <= count_enable;
   end

   // R8 prescaler and counter
   always_ff @(posedge clock)
   begin
      if (sys_rst || counter_reset)
      begin
         prescale_count <= MPT_COUNT_RST;
         count_value <= MPT_COUNT_RST;
      end
      else if (active_cnt && src_event)
      begin
         prescale_count <= pre_wrap ? MPT_COUNT_RST : prescale_count + 1'b1;
         // R6 reset action beats increment
         if (tick)
            count_value <= any_reset ? MPT_COUNT_RST : count_value + 1'b1;
      end
   end

   // R6 stop on match
   always_ff @(posedge clock)
   begin
      if (sys_rst || !count_enable)
         stopped <= 1'b0;
      else if (any_stop)
         stopped <= 1'b1;
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         match_flag <= MPT_FLAG_RST;
         pwm_out <= MPT_OUT_RST[5:0];
         irq <= 1'b0;
      end
      else
      begin
         match_flag <= next_flag;
         pwm_out <= next_out;
         irq <= |next_flag;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   sequence seq_period_hit;
      pwm_mode && period_hit && !counter_reset;
   endsequence

   sequence seq_single_start;
      seq_period_hit ##0 out_enable[0] && !hit[1] &&
         active[1] != MPT_MATCH_RST;
   endsequence

   AST_PERIOD_RESTART: assert property (seq_period_hit |=> count_value == 0) // R1
      else $error("Counter did not restart at period match");
   AST_SINGLE_RISE: assert property (seq_single_start |=> pwm_out[0]) // R2
      else $error("Single edge output did not rise");
   AST_CONST_LOW: assert property (pwm_mode && active[1] == 0 && // R3
      !pwm_out[0] |=> !pwm_out[0])
      else $error("Constant low output rose");
   AST_DOUBLE_RISE: assert property (pwm_mode && out_enable[2] && // R4
      double_sel[2] && hit[2] && !hit[3] |=> pwm_out[2])
      else $error("Double edge output did not rise");
   AST_STOP: assert property (any_stop && count_enable |=> stopped ##1 // R6
      $stable(count_value))
      else $error("Counter did not stop on match");
   AST_PRESCALE: assert property ($changed(count_value) && // R8
      !$past(counter_reset) |-> $past(prescale_count) == $past(prescale))
      else $error("Counter advanced before prescale wrap");
   AST_HELD_UNTIL_RELEASE: assert property ($past(pwm_mode) && // R9
      !$stable(active[1]) |-> $past(period_hit) && $past(pending[1]))
      else $error("Match value applied without release");
   AST_FLAG_SET: assert property (hit[4] && act_irq[4] |=> match_flag[4]) // R16
      else $error("Match flag not set");
   AST_FLAG_HOLD: assert property (match_flag[4] && !flag_clear[4] // R16
      |=> match_flag[4])
      else $error("Match flag lost without clear");
   AST_SLAVE_LOCK: assert property (slave_mode && !sync_run_in && // R11
      !counter_reset |=> $stable(count_value))
      else $error("Slave counted without master run");
endmodule

// ### design/mpt_pkg.sv
// Shared constants of the match based modulation timer
package mpt_pkg;
   localparam int MPT_NUM_MATCH = 7;
   localparam int MPT_NUM_OUT = 6;
   localparam int MPT_CNT_W = 32;
   localparam int MPT_IDX_W = 3;
   localparam int MPT_NUM_CAP = 4;
   // Per match action field: three bits per match register
   localparam int MPT_ACT_W = 3;
   localparam int MPT_ACT_IRQ = 0;
   localparam int MPT_ACT_RESET = 1;
   localparam int MPT_ACT_STOP = 2;
   localparam logic [31:0] MPT_COUNT_RST = 32'h0000_0000;
   localparam logic [31:0] MPT_MATCH_RST = 32'h0000_0000;
   localparam logic [6:0] MPT_FLAG_RST = 7'h00;
   localparam logic [6:0] MPT_OUT_RST = 7'h00;

   typedef enum logic [1:0]
   {
      MPT_SRC_CLOCK = 2'b00,
      MPT_SRC_RISE = 2'b01,
      MPT_SRC_FALL = 2'b10,
      MPT_SRC_BOTH = 2'b11
   } mpt_src_t;
endpackage

// ### design/mpt_match_bank.sv
// Holding and active match values with software release
`timescale 1ns/10ps
module mpt_match_bank
#(
   parameter int WIDTH = mpt_pkg::MPT_CNT_W,
   parameter int DEPTH = mpt_pkg::MPT_NUM_MATCH
)
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic wr_en,
   input wire logic [mpt_pkg::MPT_IDX_W-1:0] wr_index,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic [DEPTH-1:0] release_set,
   input wire logic direct,
   input wire logic apply,
   output logic [DEPTH-1:0][WIDTH-1:0] active,
   output logic [DEPTH-1:0] pending
);
   import mpt_pkg::*;

   logic [DEPTH-1:0][WIDTH-1:0] shadow;
   logic [DEPTH-1:0] wr_hit;
   logic [DEPTH-1:0] take;

   always_comb
   begin
      for (int i = 0; i < DEPTH; i++)
      begin
         wr_hit[i] = wr_en && (wr_index == MPT_IDX_W'(i));
         take[i] = !direct && apply && pending[i];
      end
   end

   always_ff @(posedge clock)
   begin
      for (int i = 0; i < DEPTH; i++)
      begin
         if (sys_rst)
         begin
            shadow[i] <= MPT_MATCH_RST;
            active[i] <= MPT_MATCH_RST;
            pending[i] <= 1'b0;
         end
         else
         begin
            if (wr_hit[i])
               shadow[i] <= wr_data;
            // R10 plain timer writes straight through
            if (direct && wr_hit[i])
               active[i] <= wr_data;
            // R15 transfer at period match
            else if (take[i])
               active[i] <= shadow[i];
            // R9 release wins over transfer
            pending[i] <= release_set[i] || (pending[i] && !take[i]);
         end
      end
   end
endmodule

// ### test/mpt_load_model.sv
// Load model counting high cycles on each output
`timescale 1ns/10ps
module mpt_load_model
(
   input wire logic clock,
   input wire logic clear,
   input wire logic [5:0] pwm_out,
   output logic [5:0][7:0] high_count
);
   always_ff @(posedge clock)
   begin
      for (int n = 0; n < 6; n++)
      begin
         if (clear)
            high_count[n] <= 8'h00;
         else if (pwm_out[n])
            high_count[n] <= high_count[n] + 8'h01;
      end
   end
endmodule

// ### test/mpt_timer_tb.sv
// Self-checking bench of the match based modulation timer
`timescale 1ns/10ps
module mpt_timer_tb;
   import mpt_pkg::*;
   typedef struct {
      logic [31:0] p, m1, m2, m3, e1, e2, e3;
   } mpt_row_t;
   logic clock, sys_rst, count_enable, counter_reset, pwm_mode;
   logic wr_en, clear, irq, run_out, stopped, slave_mode, sync_run_in;
   logic [31:0] prescale, wr_data, count_value, prescale_count;
   logic [20:0] match_ctrl;
   logic [5:0] double_sel, out_enable, pwm_out;
   logic [2:0] wr_index;
   logic [6:0] release_set, flag_clear, match_flag;
   logic [5:0][7:0] high_count;
   int errors, check_count, k;
   mpt_row_t rows [3];
   mpt_timer i_mpt_timer (.clock(clock), .sys_rst(sys_rst),
      .count_enable(count_enable), .counter_reset(counter_reset),
      .pwm_mode(pwm_mode), .slave_mode(slave_mode),
      .sync_run_in(sync_run_in),
      .count_src(MPT_SRC_CLOCK), .cap_sel(2'h0), .cap_in(4'h0),
      .prescale(prescale), .match_ctrl(match_ctrl),
      .double_sel(double_sel), .out_enable(out_enable), .wr_en(wr_en),
      .wr_index(wr_index), .wr_data(wr_data), .release_set(release_set),
      .flag_clear(flag_clear), .pwm_out(pwm_out), .match_flag(match_flag),
      .irq(irq), .run_out(run_out), .stopped(stopped),
      .count_value(count_value), .prescale_count(prescale_count));
   mpt_load_model i_mpt_load_model (.clock(clock), .clear(clear),
      .pwm_out(pwm_out), .high_count(high_count));
   task automatic complete_run();
      if (errors == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input int idx, input logic [31:0] d,
                     input logic [6:0] rel);
      @(posedge clock);
      wr_en <= 1'h1;
      wr_index <= 3'(idx);
      wr_data <= d;
      @(posedge clock);
      wr_en <= 1'h0;
      release_set <= rel;
      @(posedge clock);
      release_set <= 7'h00;
   endtask
   // Settle, then count high cycles over one window
   task automatic measure(input int w);
      repeat (3 * w) @(posedge clock);
      clear <= 1'h1;
      @(posedge clock);
      clear <= 1'h0;
      repeat (w) @(posedge clock);
      #1;
   endtask
   initial
   begin
      clock = 1'h0;
      forever #25 clock = ~clock;
   end
   initial
   begin
      {sys_rst, count_enable, counter_reset, pwm_mode, wr_en} = 5'h10;
      {clear, prescale, wr_data, match_ctrl, wr_index} = '0;
      {release_set, flag_clear, double_sel, out_enable} = '0;
      {slave_mode, sync_run_in} = 2'h0;
      errors = 0;
      check_count = 0;
      rows = '{'{0, 4, 6, 2, 5, 7, 6}, '{0, 0, 2, 6, 0, 3, 4},
               '{1, 8, 3, 5, 18, 8, 4}};
      repeat (16) @(posedge clock);
      sys_rst <= 1'h0;
      @(posedge clock);
      #1;
      chk({pwm_out, match_flag, irq, stopped}, 32'h0);
      chk(count_value, MPT_COUNT_RST);
      pwm_mode <= 1'h1;
      out_enable <= 6'h3f;
      double_sel <= 6'h04;
      count_enable <= 1'h1;
      wr(0, 32'h9, 7'h01);
      foreach (rows[r])
      begin
         prescale <= rows[r].p;
         wr(1, rows[r].m1, 7'h02);
         wr(2, rows[r].m2, 7'h04);
         wr(3, rows[r].m3, 7'h08);
         measure(10 * (int'(rows[r].p) + 1));
         chk(32'(high_count[0]), rows[r].e1);
         chk(32'(high_count[1]), rows[r].e2);
         chk(32'(high_count[2]), rows[r].e3);
      end
      wr(1, 32'h2, 7'h00);
      measure(20);
      chk(32'(high_count[0]), 32'd18);
      wr(1, 32'h2, 7'h02);
      measure(20);
      chk(32'(high_count[0]), 32'd6);
      out_enable <= 6'h3e;
      measure(20);
      chk(32'(high_count[0]), 32'd0);
      pwm_mode <= 1'h0;
      counter_reset <= 1'h1;
      prescale <= 32'h0;
      wr(4, 32'h5, 7'h00);
      match_ctrl <= 21'h005000;
      counter_reset <= 1'h0;
      k = 0;
      while (stopped !== 1'h1 && k < 40)
      begin
         @(posedge clock);
         #1;
         k++;
      end
      if (k == 40)
      begin
         errors++;
         complete_run();
      end
      repeat (3) @(posedge clock);
      #1;
      chk(count_value, 32'h6);
      chk({pwm_out, irq, match_flag}, 32'h0090);
      flag_clear <= 7'h08;
      @(posedge clock);
      flag_clear <= 7'h10;
      #1;
      chk(32'(match_flag), 32'h10);
      @(posedge clock);
      flag_clear <= 7'h00;
      #1;
      chk({irq, match_flag}, 32'h0);
      // Slave held until master run arrives
      count_enable <= 1'h0;
      match_ctrl <= 21'h0;
      slave_mode <= 1'h1;
      counter_reset <= 1'h1;
      @(posedge clock);
      counter_reset <= 1'h0;
      count_enable <= 1'h1;
      repeat (4) @(posedge clock);
      #1;
      chk(count_value, 32'h0);
      chk(32'(run_out), 32'h1);
      sync_run_in <= 1'h1;
      repeat (3) @(posedge clock);
      #1;
      chk(count_value, 32'h3);
      chk(prescale_count, 32'h0);
      complete_run();
   end
endmodule
